// File: drs_pkg.sv
/*
 * Shared constants and types for the delayed-issue request front end:
 * register offsets and reset values, packet and command carriers.
 * Assumes a single 100 MHz clock and an APB register port.
 */
package drs_pkg;
	localparam int          BANK_W      = 3;
	localparam int          ROW_W       = 12;
	localparam int          COL_W       = 6;
	localparam int          LAT_W       = 8;
	localparam int          MAX_WAIT    = 3;
	localparam int          REF_DLY_LSB = 6;
	localparam int          REF_DLY_MSB = 7;
	localparam int          APB_AW      = 8;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_LAT     = 8'h04;
	localparam logic [7:0]  OFS_STAT    = 8'h08;
	localparam logic        CTRL_RST    = 1'h1;
	localparam logic [7:0]  FETCH_RST   = 8'h08;
	localparam logic [7:0]  STORE_RST   = 8'h04;
	localparam int          LAT_STORE_LSB = 8;
	localparam int          STAT_ROW_LSB  = 16;

	typedef enum logic [2:0] {
		PKT_NONE, PKT_OPEN, PKT_READ, PKT_WRITE, PKT_MWRITE, PKT_CLOSE
	} drs_pkt_kind_t;

	typedef enum logic [1:0] {
		REF_NONE, REF_CLOSE, REF_OPEN, REF_OPEN_INC
	} drs_ref_op_t;

	typedef struct packed {
		logic                valid;
		drs_pkt_kind_t       kind;
		logic                open_wait_field;
		logic                access_wait_field;
		logic                close_op;
		logic [1:0]          wait_field;
		logic [BANK_W-1:0]   close_bank_field;
		drs_ref_op_t         refresh_op_field;
		logic [ROW_W-1:0]    refresh_row_field;
		logic [BANK_W-1:0]   bank;
		logic [ROW_W-1:0]    row;
		logic [COL_W-1:0]    col;
	} drs_req_t;

	typedef struct packed {
		logic                valid;
		logic [1:0]          op;
		logic [BANK_W-1:0]   bank;
		logic [ROW_W-1:0]    addr;
	} drs_cmd_t;
endpackage

// File: drs_delay_pipe.sv
/*
 * Slot line that postpones a command by 0..MAXD cycles, plus one
 * output register. Assumes the sender never lands two commands on
 * the same effective cycle; a new entry overwrites a shifted one.
 */
`timescale 1ns/1ps
module drs_delay_pipe #(
	parameter int W    = 8,
	parameter int MAXD = 3
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	input  wire logic [1:0]   in_delay,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	output logic [W-1:0]      out_data
);
	logic [MAXD:0]  slot_v;
	logic [W-1:0]   slot_d [MAXD:0];

	// Slot 0 is the effective cycle; output register adds one cycle
	assign slot_v[MAXD] = 1'b0;
	assign slot_d[MAXD] = '0;

	genvar i;
	generate
		for (i = 0; i < MAXD; i++) begin : g_slot
			logic         v;
			logic [W-1:0] d;
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					v <= 1'b0;
					d <= '0;
				end else if (in_valid && in_delay == 2'(i + 1)) begin
					v <= 1'b1;
					d <= in_data;
				end else begin
					v <= slot_v[i+1];
					d <= slot_d[i+1];
				end
			end
			assign slot_v[i] = v;
			assign slot_d[i] = d;
		end
	endgenerate

	wire now_in = in_valid && in_delay == 2'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			out_valid <= now_in | slot_v[0];
			out_data  <= now_in ? in_data : slot_d[0];
		end
	end
endmodule

// File: drs_request_front.sv
/*
 * Request front end of a multi-bank DRAM: takes request packets,
 * applies their wait fields, and issues effective open, column,
 * close and refresh commands, then times data start from the
 * effective column cycle. Registers over APB.
 * Assumes the controller keeps all inter-command spacing itself.
 */
`timescale 1ns/1ps
// Overview of operation
// R01 - Controller spaces opens to different banks
// R02 - Same-bank opens bank-cycle apart, close between
// R03 - Read to close no earlier than fetch-to-close
// R04 - Write to close, then close-to-open before reopen
// R05 - Close to open same bank: close-to-open time
// R06 - Open to read same bank: open-to-fetch time
// R07 - Reads spaced by burst spacing time
// R08 - Writes spaced by burst spacing time
// R09 - Write to read: store-to-fetch turnaround
// R10 - Read to write: fetch-to-store turnaround
// R11 - Open to write same bank: open-to-store time
// R12 - Closed bank reopened before any access
// R13 - Bank stays open minimum time before close
// R14 - Closes to different banks spaced apart
// R15 - Same-bank closes bank-cycle apart, open between
// R16 - Device honours wait fields in all packets
// R17 - One-bit wait equals packet one cycle later
// R18 - Data latency counts from effective column cycle
// R19 - Close wait field delays zero to three
// R20 - Refresh delay from upper row field bits; code uses bits 7:6 of the 12-bit field
// R21 - Close packet carries two independent operations
// R22 - Controller uses longer of both constraints
// R23 - Never close and refresh same bank together
// R24 - Spacing measured at effective positions, else zero
// R25 - Controller tracks per-bank effective command times
module drs_request_front
	import drs_pkg::*;
#(
	parameter int MAX_LAT = 64
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [drs_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire drs_pkg::drs_req_t     req,
	output drs_pkg::drs_cmd_t          open_cmd,
	output drs_pkg::drs_cmd_t          col_cmd,
	output drs_pkg::drs_cmd_t          close_cmd,
	output drs_pkg::drs_cmd_t          refresh_cmd,
	output logic                       fetch_data_start,
	output logic                       store_data_start
);
	import drs_pkg::*;

	localparam int CW = $bits(drs_cmd_t);

	logic              enable;
	logic [LAT_W-1:0]  fetch_data_delay;
	logic [LAT_W-1:0]  store_data_delay;
	logic [15:0]       cmd_count;
	logic [ROW_W-1:0]  refresh_row;
	logic [MAX_LAT:0]  fetch_line;
	logic [MAX_LAT:0]  store_line;

	// APB: zero wait states, errors on unmapped offsets
	wire apb_acc   = psel && penable;
	wire hit_ctrl  = paddr == OFS_CTRL;
	wire hit_lat   = paddr == OFS_LAT;
	wire hit_stat  = paddr == OFS_STAT;
	wire hit_any   = hit_ctrl | hit_lat | hit_stat;
	wire wr_ctrl   = apb_acc && pwrite && hit_ctrl;
	wire wr_lat    = apb_acc && pwrite && hit_lat;

	assign pready  = 1'b1;
	assign pslverr = apb_acc && !hit_any;

	wire [31:0] rd_ctrl = {31'h0, enable};
	wire [31:0] rd_lat  = {16'h0, store_data_delay, fetch_data_delay};
	wire [31:0] rd_stat = {4'h0, refresh_row, cmd_count};
	wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl : hit_lat ? rd_lat : hit_stat ? rd_stat : 32'h0;
	assign prdata = (apb_acc && !pwrite) ? rd_mux : 32'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable           <= CTRL_RST;
			fetch_data_delay <= FETCH_RST;
			store_data_delay <= STORE_RST;
		end else begin
			if (wr_ctrl)
				enable <= pwdata[0];
			if (wr_lat) begin
				fetch_data_delay <= pwdata[LAT_W-1:0];
				store_data_delay <= pwdata[LAT_STORE_LSB +: LAT_W];
			end
		end
	end

	// Packet decode; disabled front end drops packets entirely
	wire take      = enable && req.valid;
	wire is_open   = take && req.kind == PKT_OPEN;
	wire is_col    = take && (req.kind == PKT_READ || req.kind == PKT_WRITE
	                          || req.kind == PKT_MWRITE);
	wire is_close  = take && req.kind == PKT_CLOSE;
	wire do_close  = is_close && req.close_op;
	wire do_ref    = is_close && req.refresh_op_field != REF_NONE;

	wire [1:0] open_dly  = {1'b0, req.open_wait_field};                       // [R17]
	wire [1:0] col_dly   = {1'b0, req.access_wait_field};                     // [R17]
	wire [1:0] close_dly = req.wait_field;                                    // [R19]
	wire [1:0] ref_dly   = req.refresh_row_field[REF_DLY_MSB:REF_DLY_LSB];    // [R20]

	wire [1:0] col_op = req.kind == PKT_READ  ? 2'h0 :
	                    req.kind == PKT_WRITE ? 2'h1 : 2'h2;

	wire drs_cmd_t open_in  = '{valid: 1'b1, op: 2'h0, bank: req.bank, addr: req.row};
	wire drs_cmd_t col_in   = '{valid: 1'b1, op: col_op, bank: req.bank,
	                            addr: ROW_W'(req.col)};
	wire drs_cmd_t close_in = '{valid: 1'b1, op: 2'h0, bank: req.close_bank_field,
	                            addr: '0};
	wire drs_cmd_t ref_in   = '{valid: 1'b1, op: req.refresh_op_field,
	                            bank: req.refresh_row_field[BANK_W-1:0],
	                            addr: req.refresh_row_field};

	logic [CW-1:0] open_q, col_q, close_q, ref_q;
	logic          open_v, col_v, close_v, ref_v;

	// Four independent lines, so close and refresh never share a delay
	drs_delay_pipe #(.W(CW), .MAXD(MAX_WAIT)) u_open (                       // [R16]
		.clk(clk), .rst(rst), .in_valid(is_open), .in_delay(open_dly),
		.in_data(open_in), .out_valid(open_v), .out_data(open_q));
	drs_delay_pipe #(.W(CW), .MAXD(MAX_WAIT)) u_col (
		.clk(clk), .rst(rst), .in_valid(is_col), .in_delay(col_dly),
		.in_data(col_in), .out_valid(col_v), .out_data(col_q));
	drs_delay_pipe #(.W(CW), .MAXD(MAX_WAIT)) u_close (                      // [R21]
		.clk(clk), .rst(rst), .in_valid(do_close), .in_delay(close_dly),
		.in_data(close_in), .out_valid(close_v), .out_data(close_q));
	drs_delay_pipe #(.W(CW), .MAXD(MAX_WAIT)) u_ref (                        // [R21]
		.clk(clk), .rst(rst), .in_valid(do_ref), .in_delay(ref_dly),
		.in_data(ref_in), .out_valid(ref_v), .out_data(ref_q));

	assign open_cmd    = open_v  ? drs_cmd_t'(open_q)  : '0;
	assign col_cmd     = col_v   ? drs_cmd_t'(col_q)   : '0;
	assign close_cmd   = close_v ? drs_cmd_t'(close_q) : '0;
	assign refresh_cmd = ref_v   ? drs_cmd_t'(ref_q)   : '0;

	// Latency lines start at the effective column, not the arrival
	wire eff_read  = col_cmd.valid && col_cmd.op == 2'h0;                     // [R18]
	wire eff_write = col_cmd.valid && col_cmd.op != 2'h0;                     // [R18]
	wire [MAX_LAT:0] fetch_set = eff_read  ? ((MAX_LAT+1)'(1) << fetch_data_delay) : '0;
	wire [MAX_LAT:0] store_set = eff_write ? ((MAX_LAT+1)'(1) << store_data_delay) : '0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_line <= '0;
			store_line <= '0;
		end else begin
			fetch_line <= (fetch_line >> 1) | (fetch_set >> 1);               // [R18]
			store_line <= (store_line >> 1) | (store_set >> 1);               // [R18]
		end
	end

	// Delay 0 fires in the effective cycle itself
	assign fetch_data_start = (eff_read  && fetch_data_delay == '0) || fetch_line[0];
	assign store_data_start = (eff_write && store_data_delay == '0) || store_line[0];

	wire ref_inc = refresh_cmd.valid && refresh_cmd.op == REF_OPEN_INC;
	wire [2:0] n_eff = 3'(open_cmd.valid) + 3'(col_cmd.valid)
	                 + 3'(close_cmd.valid) + 3'(refresh_cmd.valid);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_count   <= '0;
			refresh_row <= '0;
		end else begin
			cmd_count <= cmd_count + 16'(n_eff);
			if (ref_inc)
				refresh_row <= refresh_row + 1'b1;
		end
	end

	// An open one cycle earlier with its wait set would land in the gap
	sequence s_open_wait;
		is_open && req.open_wait_field && !$past(is_open && req.open_wait_field);
	endsequence
	sequence s_open_now;
		is_open && !req.open_wait_field;
	endsequence

	AST_OPEN_WAIT_ONE: assert property (@(posedge clk) disable iff (rst) // [R17]
		s_open_wait |-> ##1 !open_cmd.valid ##1 open_cmd.valid)
		else $error("open with wait set not issued one cycle late");
	AST_OPEN_NOW: assert property (@(posedge clk) disable iff (rst) // [R16]
		s_open_now |=> open_cmd.valid && open_cmd.addr == $past(req.row))
		else $error("open without wait not issued next cycle");
	AST_COL_WAIT: assert property (@(posedge clk) disable iff (rst) // [R17]
		is_col && req.access_wait_field && !$past(is_col && req.access_wait_field)
		|=> !col_cmd.valid ##1 col_cmd.valid)
		else $error("column with wait set not postponed one cycle");
	AST_CLOSE_DELAY: assert property (@(posedge clk) disable iff (rst) // [R19]
		do_close && req.wait_field == 2'h3 |-> ##4 close_cmd.valid)
		else $error("close with wait 3 not issued four cycles later");
	AST_REF_DELAY: assert property (@(posedge clk) disable iff (rst) // [R20]
		do_ref && req.refresh_row_field[7:6] == 2'h2 |-> ##3 refresh_cmd.valid)
		else $error("refresh with delay 2 not issued three cycles later");
	AST_INDEP: assert property (@(posedge clk) disable iff (rst) // [R21]
		do_close && do_ref && req.wait_field == 2'h0 && req.refresh_row_field[7:6] == 2'h1
		|=> close_cmd.valid && !refresh_cmd.valid ##1 refresh_cmd.valid)
		else $error("close and refresh delays not independent");
	AST_FETCH_LAT: assert property (@(posedge clk) disable iff (rst) // [R18]
		eff_read && fetch_data_delay == 8'h2 && !wr_lat |-> ##2 fetch_data_start)
		else $error("fetch data not started after latency");
	AST_STORE_LAT: assert property (@(posedge clk) disable iff (rst) // [R18]
		eff_write && store_data_delay == 8'h1 && !wr_lat |=> store_data_start)
		else $error("store data not started after latency");
endmodule

// File: drs_ctrl_model.sv
/*
 * Controller-side model: sends request packets one at a time.
 * Assumes the bench calls send from one process, never overlapped.
 */
`timescale 1ns/1ps
module drs_ctrl_model
	import drs_pkg::*;
#(
	parameter int GAP = 12
) (
	input  wire logic        clk,
	output drs_pkg::drs_req_t req
);
	// Gap outlasts every spacing, counted past the latest possible delay
	localparam int SPAN = GAP + MAX_WAIT;

	initial req = '0;

	task automatic send(input drs_req_t p);
		drs_req_t q;
		q = p;
		// Close and refresh never aim at one bank in a packet
		if (q.close_op && q.refresh_row_field[2:0] == q.close_bank_field) begin
			q.refresh_op_field = REF_NONE;
		end
		repeat (SPAN) @(posedge clk);
		req <= q;
		@(posedge clk);
		req <= '0;
	endtask
endmodule

// File: drs_request_front_tb.sv
/*
 * Self-checking bench for the request front end: APB register checks,
 * wait-field timing of every command kind, data start latency.
 * Assumes the controller model drives req and the bench drives APB.
 */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module drs_request_front_tb;
	import drs_pkg::*;
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fds;
	logic        sds;
	drs_req_t    req;
	drs_cmd_t    open_cmd;
	drs_cmd_t    col_cmd;
	drs_cmd_t    close_cmd;
	drs_cmd_t    refresh_cmd;
	drs_cmd_t    cv [4];
	drs_cmd_t    seen [4];
	logic [5:0]  vv;
	logic [31:0] rd;
	logic        err;
	int          at [6];
	int          fail_count = 0;
	int          n_checks = 0;

	assign cv = '{open_cmd, col_cmd, close_cmd, refresh_cmd};
	assign vv = {sds, fds, refresh_cmd.valid, close_cmd.valid, col_cmd.valid, open_cmd.valid};

	drs_request_front drs_request_front_i (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
		.open_cmd(open_cmd), .col_cmd(col_cmd), .close_cmd(close_cmd),
		.refresh_cmd(refresh_cmd), .fetch_data_start(fds), .store_data_start(sds));
	drs_ctrl_model drs_ctrl_model_i (.clk(clk), .req(req));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		`CHK("pready", 1'b1, pready)
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// First cycle each output pulses, counted from the taking edge
	task automatic watch();
		for (int i = 0; i < 6; i++) at[i] = 99;
		#1;
		for (int c = 0; c < 10; c++) begin
			for (int i = 0; i < 6; i++) begin
				if (vv[i] === 1'b1 && at[i] == 99) begin
					at[i] = c;
					if (i < 4) seen[i] = cv[i];
				end
			end
			@(posedge clk);
			#1;
		end
	endtask

	function automatic drs_req_t mk(drs_pkt_kind_t k, logic [1:0] w);
		drs_req_t p;
		p = '0;
		p.valid = 1'b1;
		p.kind = k;
		p.open_wait_field = w[0];
		p.access_wait_field = w[0];
		p.wait_field = w;
		p.close_op = (k == PKT_CLOSE);
		p.close_bank_field = 3'h1;
		p.bank = 3'h3;
		p.row = 12'h5C1;
		p.col = 6'h2A;
		return p;
	endfunction

	task automatic t_regs();
		apb(1'b0, OFS_CTRL, '0);
		`CHK("ctrl", 32'h0000_0001, rd)
		`CHK("ctrl err", 1'b0, err)
		apb(1'b0, OFS_LAT, '0);
		`CHK("lat", {16'h0000, STORE_RST, FETCH_RST}, rd)
		apb(1'b0, OFS_STAT, '0);
		`CHK("stat", 32'h0000_0000, rd)
		apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		`CHK("unmapped wr err", 1'b1, err)
		apb(1'b0, 8'h0C, '0);
		`CHK("unmapped rd", 33'h1_0000_0000, {err, rd})
	endtask

	task automatic t_open();
		for (int w = 0; w < 2; w++) begin
			drs_ctrl_model_i.send(mk(PKT_OPEN, w[1:0]));
			watch();
			`CHK("open time", w, at[0])
			`CHK("open addr", 15'h35C1, {seen[0].bank, seen[0].addr})
		end
	endtask

	// Latencies chosen so that zero, one, two and the longer lines all run
	task automatic t_col();
		drs_pkt_kind_t ks [3];
		logic [31:0]   lats [3];
		int            dl;
		ks = '{PKT_READ, PKT_WRITE, PKT_MWRITE};
		lats = '{32'h0000_0503, 32'h0000_0102, 32'h0000_0000};
		for (int l = 0; l < 3; l++) begin
			apb(1'b1, OFS_LAT, lats[l]);
			apb(1'b0, OFS_LAT, '0);
			`CHK("lat wr", lats[l], rd)
			for (int i = 0; i < 3; i++) begin
				drs_ctrl_model_i.send(mk(ks[i], 2'h1));
				watch();
				dl = (i == 0) ? int'(lats[l][7:0]) : int'(lats[l][15:8]);
				`CHK("col time", 1, at[1])
				`CHK("col op addr", {i[1:0], 12'h02A}, {seen[1].op, seen[1].addr})
				`CHK("data start", dl + 1, (i == 0) ? at[4] : at[5])
				`CHK("other start", 99, (i == 0) ? at[5] : at[4])
			end
		end
	endtask

	task automatic t_close();
		for (int w = 0; w < 4; w++) begin
			drs_ctrl_model_i.send(mk(PKT_CLOSE, w[1:0]));
			watch();
			`CHK("close time", w, at[2])
			`CHK("close bank", 3'h1, seen[2].bank)
			`CHK("no refresh", 99, at[3])
		end
	endtask

	task automatic t_ref();
		drs_req_t p;
		for (int op = 1; op < 4; op++) begin
			p = mk(PKT_CLOSE, 2'(op - 1));
			p.refresh_op_field = drs_ref_op_t'(op);
			p.refresh_row_field = {4'hA, 2'(op), 3'h0, 3'h6};
			drs_ctrl_model_i.send(p);
			watch();
			`CHK("ref time", op, at[3])
			`CHK("close time", op - 1, at[2])
			`CHK("ref op", 2'(op), seen[3].op)
			`CHK("ref row", p.refresh_row_field, seen[3].addr)
			`CHK("banks", 6'o16, {seen[2].bank, seen[3].bank})
		end
		apb(1'b0, OFS_STAT, '0);
		`CHK("stat", 32'h0001_0015, rd)
	endtask

	task automatic t_dis();
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		drs_ctrl_model_i.send(mk(PKT_OPEN, 2'h0));
		watch();
		`CHK("dropped open", 99, at[0])
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		drs_ctrl_model_i.send(mk(PKT_OPEN, 2'h0));
		watch();
		`CHK("open again", 0, at[0])
	endtask

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_open();
		t_col();
		t_close();
		t_ref();
		t_dis();
		summarize();
	end

	// Whole run takes well under a thousand cycles
	initial begin
		#50000;
		fail_count++;
		summarize();
	end
endmodule
